// >>> src/livw_device.sv
`timescale 1ns/1ns
module livw_device
  import livw_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // link to the system
  livw_if.device          link,
  // software register port
  input  wire logic [3:0] regAddr,
  input  wire logic [8:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [8:0] regRdData,
  // interrupt delivery to the core
  output logic            coreIrq,
  output logic      [7:0] coreVector,
  input  wire logic       coreIrqTaken
);
  import livw_pkg::*;

  logic [8:0] spuriousVector_r;
  logic       tr12Disable_r;
  logic       strapEnable_r;
  logic       floatOutputs_r;
  logic       warmLatch_r;
  logic       inReset_r;
  logic       ctrlEnabled;
  logic       inService_r;
  logic [7:0] vector_r;
  livw_ack_t  ackState_r;
  logic       writeBusy_r;
  logic [1:0] writeCnt_r;
  logic [3:0] writeAddr_r;
  logic       restartPending_r;
  logic       holdAck_r;
  logic       ackPending;

  // straps are taken in the first clocked cycle after reset release
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      inReset_r      <= 1'b1;
      strapEnable_r  <= 1'b0;
      floatOutputs_r <= 1'b0;
    end else if (inReset_r) begin
      inReset_r      <= 1'b0;
      strapEnable_r  <= link.localIrqCtrlEnableStrap;
      floatOutputs_r <= !link.redundancyMasterCheckerStrap;  // active low, ignored later
    end
  end

  // test register disable: stays off until warm reset once it was set
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tr12Disable_r <= 1'b0;
      warmLatch_r   <= 1'b0;
    end else if (regWrite && regAddr == TEST_CONTROL_REG_TWELVE_ADDR) begin
      tr12Disable_r <= regWrData[TEST_CONTROL_REG_TWELVE_DISABLE_BIT];
      if (regWrData[TEST_CONTROL_REG_TWELVE_DISABLE_BIT])
        warmLatch_r <= 1'b1;
    end
  end

  // spurious vector register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      spuriousVector_r <= SPURIOUS_VECTOR_RESET;
    else if (regWrite && regAddr == SPURIOUS_VECTOR_REG_ADDR)
      spuriousVector_r <= regWrData;
  end

  // overall enable
  assign ctrlEnabled = strapEnable_r && !warmLatch_r && !tr12Disable_r
                     && spuriousVector_r[SVR_ENABLE_BIT];

  // register write runs internally while its address shows on the bus
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      writeBusy_r      <= 1'b0;
      writeCnt_r       <= 2'h0;
      writeAddr_r      <= 4'h0;
      restartPending_r <= 1'b0;
    end else begin
      if (regWrite && !writeBusy_r) begin
        writeBusy_r <= 1'b1;
        writeCnt_r  <= 2'(WRITE_BUS_CYCLES - 1);
        writeAddr_r <= regAddr;
      end else if (writeBusy_r) begin
        if (link.busHoldRequest || link.busBackoff)
          restartPending_r <= 1'b1;                          // write still completes
        if (writeCnt_r == 2'h0)
          writeBusy_r <= 1'b0;
        else
          writeCnt_r <= writeCnt_r - 2'h1;
      end else if (restartPending_r && !link.busHoldRequest && !holdAck_r && !link.busBackoff) begin
        restartPending_r <= 1'b0;                            // restart after hold and backoff released
        writeBusy_r      <= 1'b1;
        writeCnt_r       <= 2'(WRITE_BUS_CYCLES - 1);
      end
    end
  end

  // hold acknowledge, granted once no internal write is on the bus
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      holdAck_r <= 1'b0;
    else if (!link.busHoldRequest)
      holdAck_r <= 1'b0;
    else if (!writeBusy_r)
      holdAck_r <= 1'b1;
  end

  // level request: pending only while the pin is high now
  assign ackPending = link.externalIrqRequest && ctrlEnabled;

  // two acknowledge cycles per request, then one wait cycle and back to idle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ackState_r <= LIVW_ACK_IDLE;
      vector_r   <= VECTOR_RESET;
    end else begin
      unique case (ackState_r)
        LIVW_ACK_IDLE:
          if (ackPending && !holdAck_r && !link.busHoldRequest && !link.busBackoff && !inService_r)
            ackState_r <= LIVW_ACK_FIRST;
        LIVW_ACK_FIRST:
          if (link.burstDataReady)
            ackState_r <= LIVW_ACK_SECND;
        LIVW_ACK_SECND:
          if (link.burstDataReady) begin
            vector_r   <= link.ackVector;
            ackState_r <= LIVW_ACK_WAIT;                     // last data-ready ends it
          end
        LIVW_ACK_WAIT:
          ackState_r <= LIVW_ACK_IDLE;
      endcase
    end
  end

  // in-service tracking: blocks every new request until end of irq
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      inService_r   <= 1'b0;
    end else if (ackState_r == LIVW_ACK_WAIT) begin
      inService_r   <= 1'b1;                                 // set wins over a same-cycle end-of-irq
    end else if (regWrite && regAddr == END_OF_IRQ_WRITE_ADDR) begin
      inService_r   <= 1'b0;
    end
  end

  // core delivery: set with the vector in the wait state, cleared when core takes it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      coreIrq    <= 1'b0;
      coreVector <= VECTOR_RESET;
    end else if (ackState_r == LIVW_ACK_WAIT) begin
      coreIrq    <= 1'b1;
      coreVector <= vector_r;
    end else if (coreIrqTaken) begin
      coreIrq    <= 1'b0;
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      regRdData <= 9'h000;
    else if (regRead) begin
      unique case (regAddr)
        SPURIOUS_VECTOR_REG_ADDR:     regRdData <= spuriousVector_r;
        TEST_CONTROL_REG_TWELVE_ADDR: regRdData <= {4'h0, tr12Disable_r, 4'h0};
        STATUS_ADDR:                  regRdData <= {3'h0, restartPending_r, holdAck_r, inService_r,
                                                    warmLatch_r, strapEnable_r, ctrlEnabled};
        IRQ_VECTOR_ADDR:              regRdData <= {1'b0, vector_r};
        default:                      regRdData <= 9'h000;
      endcase
    end else
      regRdData <= 9'h000;
  end

  // link outputs, all released when the redundancy strap was active
  assign link.outputsEnable       = !floatOutputs_r;
  assign link.busHoldAcknowledge  = holdAck_r && !floatOutputs_r;
  assign link.irqAcknowledgeCycle = (ackState_r == LIVW_ACK_FIRST || ackState_r == LIVW_ACK_SECND)
                                    && !floatOutputs_r;
  assign link.lapicWriteActive    = writeBusy_r && !floatOutputs_r;
  assign link.lapicAddress        = floatOutputs_r ? 4'h0 : writeAddr_r;
endmodule

// >>> src/livw_pkg.sv
package livw_pkg;
  // software register map of the device end (word offsets)
  localparam logic [3:0] SPURIOUS_VECTOR_REG_ADDR      = 4'h0;
  localparam logic [3:0] TEST_CONTROL_REG_TWELVE_ADDR  = 4'h1;
  localparam logic [3:0] END_OF_IRQ_WRITE_ADDR         = 4'h2;
  localparam logic [3:0] STATUS_ADDR                   = 4'h3;
  localparam logic [3:0] IRQ_VECTOR_ADDR               = 4'h4;
  // software register map of the host end (word offsets)
  localparam logic [3:0] HOST_CTRL_ADDR                = 4'h0;
  localparam logic [3:0] HOST_STATUS_ADDR              = 4'h1;
  // field positions
  localparam int         SVR_ENABLE_BIT                = 8;
  localparam int         TEST_CONTROL_REG_TWELVE_DISABLE_BIT              = 4;
  // reset values
  localparam logic [8:0] SPURIOUS_VECTOR_RESET         = 9'h0FF;
  localparam logic [7:0] VECTOR_RESET                  = 8'h20;
  // timing counts (cycles)
  localparam int         WRITE_BUS_CYCLES              = 2;
  localparam int         ACK_DATA_CYCLES               = 2;
  localparam int         HOLD_GUARD_CYCLES             = 4;
  // acknowledge sequencer states (gray along the path)
  typedef enum logic [1:0] {
    LIVW_ACK_IDLE  = 2'b00,
    LIVW_ACK_FIRST = 2'b01,
    LIVW_ACK_SECND = 2'b11,
    LIVW_ACK_WAIT  = 2'b10
  } livw_ack_t;
endpackage

// >>> src/livw_if.sv
`timescale 1ns/1ns
interface livw_if;
  logic       externalIrqRequest;
  logic       busHoldRequest;
  logic       busBackoff;
  logic       busHoldAcknowledge;
  logic       irqAcknowledgeCycle;
  logic       burstDataReady;
  logic [7:0] ackVector;
  logic       lapicWriteActive;
  logic [3:0] lapicAddress;
  logic       localIrqCtrlEnableStrap;
  logic       redundancyMasterCheckerStrap;
  logic       outputsEnable;
  modport device (
    input  externalIrqRequest, busHoldRequest, busBackoff, burstDataReady, ackVector,
    input  localIrqCtrlEnableStrap, redundancyMasterCheckerStrap,
    output busHoldAcknowledge, irqAcknowledgeCycle, lapicWriteActive, lapicAddress, outputsEnable
  );
  modport host (
    output externalIrqRequest, busHoldRequest, busBackoff, burstDataReady, ackVector,
    output localIrqCtrlEnableStrap, redundancyMasterCheckerStrap,
    input  busHoldAcknowledge, irqAcknowledgeCycle, lapicWriteActive, lapicAddress, outputsEnable
  );
endinterface

// >>> src/livw_host.sv
`timescale 1ns/1ns
module livw_host
  import livw_pkg::*;
#(
  parameter int ACK_DATA_WAIT = ACK_DATA_CYCLES
)(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // link to the device
  livw_if.host            link,
  // software register port
  input  wire logic [3:0] regAddr,
  input  wire logic [8:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [8:0] regRdData,
  // interrupt source and vector
  input  wire logic       sourceIrq,
  input  wire logic [7:0] sourceVector
);
  import livw_pkg::*;

  logic       enableStrap_r;
  logic       frcStrap_r;
  logic       holdWant_r;
  logic       backoffWant_r;
  logic       irqLine_r;
  logic       ackBusy_r;
  logic [1:0] ackSeen_r;
  logic [3:0] dataCnt_r;
  logic       readyPulse_r;
  logic [3:0] guard_r;
  logic       prevWrite_r;

  // control register: straps and bus requests
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      enableStrap_r <= 1'b1;
      frcStrap_r    <= 1'b1;
      holdWant_r    <= 1'b0;
      backoffWant_r <= 1'b0;
    end else if (regWrite && regAddr == HOST_CTRL_ADDR) begin
      enableStrap_r <= regWrData[0];
      frcStrap_r    <= regWrData[1];
      holdWant_r    <= regWrData[2];
      backoffWant_r <= regWrData[3];
    end
  end

  // guard after any register write leaves the bus
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      guard_r     <= 4'h0;
      prevWrite_r <= 1'b0;
    end else begin
      prevWrite_r <= link.lapicWriteActive;
      if (link.lapicWriteActive)
        guard_r <= 4'(HOLD_GUARD_CYCLES);
      else if (guard_r != 4'h0)
        guard_r <= guard_r - 4'h1;
    end
  end

  // one request at a time; both acknowledges must end first
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irqLine_r <= 1'b0;
      ackBusy_r <= 1'b0;
      ackSeen_r <= 2'h0;
    end else if (!ackBusy_r) begin
      irqLine_r <= sourceIrq;
      if (sourceIrq)
        ackBusy_r <= 1'b1;
    end else begin
      if (readyPulse_r && ackSeen_r != 2'h2)
        ackSeen_r <= ackSeen_r + 2'h1;
      if (ackSeen_r == 2'h2) begin
        irqLine_r <= 1'b0;                                   // drop after second data-ready
        ackBusy_r <= 1'b0;
        ackSeen_r <= 2'h0;
      end
    end
  end

  // data-ready for each acknowledge cycle after a fixed wait
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dataCnt_r    <= 4'h0;
      readyPulse_r <= 1'b0;
    end else begin
      readyPulse_r <= 1'b0;
      if (link.irqAcknowledgeCycle && !readyPulse_r) begin
        if (dataCnt_r == 4'(ACK_DATA_WAIT - 1)) begin
          readyPulse_r <= 1'b1;
          dataCnt_r    <= 4'h0;
        end else
          dataCnt_r <= dataCnt_r + 4'h1;
      end
    end
  end

  // status read, one cycle after the strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      regRdData <= 9'h000;
    else if (regRead && regAddr == HOST_STATUS_ADDR)
      regRdData <= {3'h0, guard_r != 4'h0, ackBusy_r, link.outputsEnable,
                    link.lapicWriteActive, link.irqAcknowledgeCycle, link.busHoldAcknowledge};
    else
      regRdData <= 9'h000;
  end

  // pins toward the device
  assign link.localIrqCtrlEnableStrap      = enableStrap_r;
  assign link.redundancyMasterCheckerStrap = frcStrap_r;
  assign link.busHoldRequest               = holdWant_r && (guard_r == 4'h0) && !prevWrite_r;
  assign link.busBackoff                   = backoffWant_r && (guard_r == 4'h0);
  assign link.externalIrqRequest           = irqLine_r;
  assign link.burstDataReady               = readyPulse_r;
  assign link.ackVector                    = sourceVector;
endmodule

// >>> sim/livw_asserts.sv
`timescale 1ns/1ns
module livw_asserts (
  // clock and reset
  input wire logic       clock,
  input wire logic       arst_n,
  // link signals
  input wire logic       externalIrqRequest,
  input wire logic       busHoldRequest,
  input wire logic       burstDataReady,
  input wire logic       busHoldAcknowledge,
  input wire logic       irqAcknowledgeCycle,
  input wire logic       lapicWriteActive,
  input wire logic [3:0] lapicAddress,
  input wire logic       outputsEnable
);
  // one clock domain for every property
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // hold handshake
  chk_hold_ack_rise: assert property (busHoldRequest && !lapicWriteActive |-> ##[1:6] busHoldAcknowledge)
    else $error("hold request not acknowledged");
  chk_hold_ack_drop: assert property ($fell(busHoldRequest) |-> ##[1:2] !busHoldAcknowledge)
    else $error("hold acknowledge kept after release");
  chk_ack_needs_hold: assert property (busHoldAcknowledge |-> $past(busHoldRequest) || $past(busHoldRequest, 2))
    else $error("hold acknowledge without request");
  chk_no_irq_in_hold: assert property (busHoldAcknowledge |-> !$rose(irqAcknowledgeCycle))
    else $error("acknowledge cycle started during hold");
  // interrupt acknowledge
  chk_ack_needs_level: assert property ($rose(irqAcknowledgeCycle) |-> $past(externalIrqRequest))
    else $error("acknowledge without a high request level");
  chk_ack_end_ready: assert property ($fell(irqAcknowledgeCycle) |-> $past(burstDataReady) || $past(burstDataReady, 2))
    else $error("acknowledge ended without data ready");
  // register writes shown on the bus
  chk_write_span: assert property ($rose(lapicWriteActive) |-> lapicWriteActive[*2] ##1 !lapicWriteActive)
    else $error("register write length wrong");
  chk_write_addr: assert property (lapicWriteActive && $past(lapicWriteActive) |-> $stable(lapicAddress))
    else $error("write address moved mid cycle");
  // floated outputs stay quiet
  chk_float_quiet: assert property (!outputsEnable |-> !busHoldAcknowledge && !irqAcknowledgeCycle && !lapicWriteActive)
    else $error("output active while floated");
  // main scenarios
  cover property ($rose(irqAcknowledgeCycle));
  cover property ($rose(lapicWriteActive) && busHoldRequest);
  cover property (busHoldAcknowledge && $past(lapicWriteActive));
endmodule

// >>> sim/tb_local_irq_virtual_wire_ctrl.sv
`timescale 1ns/1ns
module tb_local_irq_virtual_wire_ctrl;
  import livw_pkg::*;
  // stimulus and observation
  logic       clock;
  logic       arst_n;
  logic [3:0] devAddr;
  logic [8:0] devWrData;
  logic       devWrite;
  logic       devRead;
  logic [8:0] devRdData;
  logic       coreIrq;
  logic [7:0] coreVector;
  logic       coreIrqTaken;
  logic [7:0] gotVector;
  logic [3:0] hostAddr;
  logic [8:0] hostWrData;
  logic       hostWrite;
  logic       hostRead;
  logic [8:0] hostRdData;
  logic       sourceIrq;
  logic [7:0] sourceVector;
  logic [8:0] rd;
  logic       ackPrev;
  logic       wrPrev;
  int         miscompares;
  int         comparisons;
  int         cycles;
  int         ackRises;
  int         wrRises;
  int         start;
  // the two ends face each other
  livw_if link ();
  livw_device u_livw_device (.clock(clock), .arst_n(arst_n), .link(link.device), .regAddr(devAddr),
    .regWrData(devWrData), .regWrite(devWrite), .regRead(devRead), .regRdData(devRdData),
    .coreIrq(coreIrq), .coreVector(coreVector), .coreIrqTaken(coreIrqTaken));
  livw_host u_livw_host (.clock(clock), .arst_n(arst_n), .link(link.host), .regAddr(hostAddr),
    .regWrData(hostWrData), .regWrite(hostWrite), .regRead(hostRead), .regRdData(hostRdData),
    .sourceIrq(sourceIrq), .sourceVector(sourceVector));
  livw_asserts u_livw_asserts (.clock(clock), .arst_n(arst_n), .externalIrqRequest(link.externalIrqRequest),
    .busHoldRequest(link.busHoldRequest), .burstDataReady(link.burstDataReady),
    .busHoldAcknowledge(link.busHoldAcknowledge), .irqAcknowledgeCycle(link.irqAcknowledgeCycle),
    .lapicWriteActive(link.lapicWriteActive), .lapicAddress(link.lapicAddress), .outputsEnable(link.outputsEnable));
  // clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // core side takes each interrupt, edge counters and run ceiling
  always @(posedge clock) begin
    coreIrqTaken <= coreIrq && !coreIrqTaken;
    if (coreIrq) gotVector <= coreVector;
    ackPrev <= link.irqAcknowledgeCycle;
    wrPrev <= link.lapicWriteActive;
    if (link.irqAcknowledgeCycle && !ackPrev) ackRises++;
    if (link.lapicWriteActive && !wrPrev) wrRises++;
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  // compare and report
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // register port cycles
  task automatic dev_wr(input logic [3:0] a, input logic [8:0] d);
    @(posedge clock);
    devAddr <= a;
    devWrData <= d;
    devWrite <= 1'b1;
    @(posedge clock);
    devWrite <= 1'b0;
  endtask
  task automatic host_wr(input logic [3:0] a, input logic [8:0] d);
    @(posedge clock);
    hostAddr <= a;
    hostWrData <= d;
    hostWrite <= 1'b1;
    @(posedge clock);
    hostWrite <= 1'b0;
  endtask
  task automatic dev_rd(input logic [3:0] a);
    @(posedge clock);
    devAddr <= a;
    devRead <= 1'b1;
    @(posedge clock);
    devRead <= 1'b0;
    #1;
    rd = devRdData;
  endtask
  task automatic host_rd(input logic [3:0] a);
    @(posedge clock);
    hostAddr <= a;
    hostRead <= 1'b1;
    @(posedge clock);
    hostRead <= 1'b0;
    #1;
    rd = hostRdData;
  endtask
  // acknowledge cycles started within a window
  task automatic expect_acks(input int n, input logic [8:0] exp);
    start = ackRises;
    repeat (n) @(posedge clock);
    check(9'(ackRises - start), exp);
  endtask
  // one interrupt end to end, then end-of-irq
  task automatic serve(input logic [7:0] v);
    sourceVector <= v;
    sourceIrq <= 1'b1;
    // one-cycle source pulse: the host holds the line until both acknowledges end
    @(posedge clock);
    sourceIrq <= 1'b0;
    expect_acks(12, 9'h001);
    check({1'b0, gotVector}, {1'b0, v});
    dev_rd(IRQ_VECTOR_ADDR);
    check(rd, {1'b0, v});
    dev_wr(END_OF_IRQ_WRITE_ADDR, 9'h000);
  endtask
  task automatic t_reset_values();
    dev_rd(SPURIOUS_VECTOR_REG_ADDR);
    check(rd, SPURIOUS_VECTOR_RESET);
    dev_rd(IRQ_VECTOR_ADDR);
    check(rd, {1'b0, VECTOR_RESET});
    dev_rd(4'hF);
    check(rd, 9'h000);
  endtask
  // spurious vector enable bit gates delivery
  task automatic t_sw_disable();
    @(posedge clock);
    sourceIrq <= 1'b1;
    expect_acks(20, 9'h000);
    sourceIrq <= 1'b0;
    dev_wr(SPURIOUS_VECTOR_REG_ADDR, 9'h1FF);
    serve(8'h41);
  endtask
  // in-service blocks, the line the host still holds is taken after end-of-irq though the source dropped, then no request is left
  task automatic t_level_and_eoi();
    sourceVector <= 8'h52;
    sourceIrq <= 1'b1;
    expect_acks(12, 9'h001);
    expect_acks(20, 9'h000);
    sourceIrq <= 1'b0;
    dev_wr(END_OF_IRQ_WRITE_ADDR, 9'h000);
    expect_acks(20, 9'h001);
    check({1'b0, gotVector}, 9'h052);
    dev_wr(END_OF_IRQ_WRITE_ADDR, 9'h000);
    expect_acks(20, 9'h000);
    serve(8'h53);
  endtask
  // hold and backoff hitting a register write
  task automatic t_write_hold();
    for (int i = 0; i < 2; i++) begin
      // let the last write and the host guard run out first
      repeat (8) @(posedge clock);
      start = wrRises;
      fork
        dev_wr(SPURIOUS_VECTOR_REG_ADDR, 9'h1FF);
        host_wr(HOST_CTRL_ADDR, (i == 0) ? 9'h007 : 9'h00B);
      join
      // write, restart, host guard, then the hold is granted in the first pass
      repeat (12) @(posedge clock);
      #1;
      if (i == 0) begin
        check({8'h00, link.busHoldAcknowledge}, 9'h001);
        host_rd(HOST_STATUS_ADDR);
        check(rd, 9'h009);
      end
      host_wr(HOST_CTRL_ADDR, 9'h003);
      repeat (12) @(posedge clock);
      #1;
      check(9'(wrRises - start), 9'h002);
      check({8'h00, link.busHoldAcknowledge}, 9'h000);
      dev_rd(SPURIOUS_VECTOR_REG_ADDR);
      check(rd, 9'h1FF);
    end
  endtask
  // test register disable lasts until a warm reset
  task automatic t_test_reg();
    dev_wr(TEST_CONTROL_REG_TWELVE_ADDR, 9'h010);
    sourceIrq <= 1'b1;
    expect_acks(20, 9'h000);
    dev_wr(TEST_CONTROL_REG_TWELVE_ADDR, 9'h000);
    expect_acks(20, 9'h000);
    sourceIrq <= 1'b0;
    arst_n <= 1'b0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    dev_wr(SPURIOUS_VECTOR_REG_ADDR, 9'h1FF);
    serve(8'h63);
  endtask
  // main sequence
  initial begin
    {devAddr, devWrData, devWrite, devRead, coreIrqTaken, gotVector} = '0;
    {hostAddr, hostWrData, hostWrite, hostRead, sourceIrq, sourceVector, ackPrev, wrPrev} = '0;
    {miscompares, comparisons, cycles, ackRises, wrRises} = '0;
    arst_n = 1'b0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    t_reset_values();
    t_sw_disable();
    t_level_and_eoi();
    t_write_hold();
    t_test_reg();
    end_of_test();
  end
endmodule
